// [logic/bpc_regs.svh]
`ifndef BPC_REGS_SVH
`define BPC_REGS_SVH

// ==========================================
// Register byte offsets
`define BPC_OFS_CTRL      4'h0
`define BPC_OFS_PWRUP     4'h4
`define BPC_OFS_DELAY     4'h8
`define BPC_OFS_STATUS    4'hc

// ==========================================
// Control register fields
`define BPC_CTRL_MODE_LO  0
`define BPC_CTRL_MODE_HI  1
`define BPC_CTRL_OE_REG   2
`define BPC_CTRL_OPEN_DR  3
`define BPC_CTRL_PRESET   4
`define BPC_CTRL_APPLY    8
`define BPC_CTRL_RST      5'h00
`define BPC_CTRL_CODE_OUT   2'h1
`define BPC_CTRL_CODE_BIDIR 2'h2

// ==========================================
// Start level fields, one bit per cell register
`define BPC_REG_IN        0
`define BPC_REG_OUT       1
`define BPC_REG_OE        2
`define BPC_PWRUP_RST     3'h0
`define BPC_CELL_REGS     3

// ==========================================
// Delay register fields
`define BPC_DLY_A_LO      0
`define BPC_DLY_B_LO      8
`define BPC_DLY_RST       4'h0

// ==========================================
// Status register fields
`define BPC_ST_IN         0
`define BPC_ST_OUT        1
`define BPC_ST_OE         2
`define BPC_ST_IN_BLOCKED 3
`define BPC_ST_MISMATCH   4
`define BPC_ST_PIN        5
`define BPC_ST_CONFIGURED 6

`endif

// [logic/bpc_pkg.sv]
package bpc_pkg;
	typedef enum logic [1:0]
	{
		BPC_MODE_IN,
		BPC_MODE_OUT,
		BPC_MODE_BIDIR
	} bpc_mode_t;
endpackage

// [logic/bpc_pin_io_cell.sv]
`include "bpc_regs.svh"

module bpc_pin_io_cell #(
	parameter int DLY_W = 4
) (
	input  wire logic                  clock_i,
	input  wire logic                  resetn_i,
	input  wire logic                  clk_en_i,
	// Avalon-MM slave
	input  wire logic [3:0]            avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [31:0]           avs_writedata_i,
	input  wire logic [3:0]            avs_byteenable_i,
	output logic      [31:0]           avs_readdata_o,
	output logic                       avs_waitrequest_o,
	// Fabric side
	input  wire logic                  fab_dout_i,
	input  wire logic                  fab_oe_i,
	input  wire logic                  fab_aclr_i,
	input  wire logic                  fab_sreset_i,
	output logic                       fab_din_o,
	output logic                       fab_comb_a_o,
	output logic                       fab_comb_b_o,
	output bpc_pkg::bpc_mode_t         mode_o,
	// Pin side
	input  wire logic                  pin_i,
	output logic                       pin_o,
	output logic                       pin_oe_o
);
	import bpc_pkg::*;

	localparam int DLY_MAX = (1 << DLY_W) - 1;

	// ==========================================
	// Declarations
	logic                  wait_q;
	logic [31:0]           rdata_q;
	logic                  req;
	logic                  wr_fire;
	logic [31:0]           rd_mux;
	logic                  wr_ctrl_lo;
	logic                  wr_ctrl_hi;
	logic                  wr_pwrup;
	logic                  wr_delay;

	bpc_mode_t             mode_q;
	logic                  oe_reg_q;
	logic                  open_dr_q;
	logic                  preset_q;
	logic                  apply_q;
	logic                  configured_q;
	logic [2:0]            pwrup_q;
	logic [DLY_W-1:0]      dly_a_q;
	logic [DLY_W-1:0]      dly_b_q;

	logic                  pin_meta_q;
	logic                  pin_sync_q;
	logic [DLY_MAX-1:0]    hist_q;
	logic                  path_a;
	logic                  path_b;
	logic                  comb_a_q;
	logic                  comb_b_q;

	logic [2:0]            cell_q;
	logic [2:0]            cell_d;
	logic [2:0]            cell_load;
	logic [2:0]            acl_hit;
	logic                  in_blocked;
	logic                  mismatch;
	logic                  eff_oe;
	logic                  pin_o_q;
	logic                  pin_oe_q;

	// ==========================================
	// Avalon-MM slave: one wait cycle, then the answer
	assign req     = avs_read_i | avs_write_i;
	assign wr_fire = avs_write_i & ~wait_q;

	// Write strobes, each live only on the completing edge
	assign wr_ctrl_lo = wr_fire & (avs_address_i == `BPC_OFS_CTRL) &
		avs_byteenable_i[0];
	assign wr_ctrl_hi = wr_fire & (avs_address_i == `BPC_OFS_CTRL) &
		avs_byteenable_i[1];
	assign wr_pwrup   = wr_fire & (avs_address_i == `BPC_OFS_PWRUP) &
		avs_byteenable_i[0];
	assign wr_delay   = wr_fire & (avs_address_i == `BPC_OFS_DELAY);

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			wait_q <= 1'b1;
		else if (clk_en_i)
			wait_q <= ~(req & wait_q);
	end

	// Unmapped addresses answer too, so a stray access cannot hang
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (avs_address_i)
			`BPC_OFS_CTRL:
			begin
				rd_mux[`BPC_CTRL_MODE_HI:`BPC_CTRL_MODE_LO] = mode_q;
				rd_mux[`BPC_CTRL_OE_REG]  = oe_reg_q;
				rd_mux[`BPC_CTRL_OPEN_DR] = open_dr_q;
				rd_mux[`BPC_CTRL_PRESET]  = preset_q;
			end
			`BPC_OFS_PWRUP:
				rd_mux[`BPC_REG_OE:`BPC_REG_IN] = pwrup_q;
			`BPC_OFS_DELAY:
			begin
				rd_mux[`BPC_DLY_A_LO +: DLY_W] = dly_a_q;
				rd_mux[`BPC_DLY_B_LO +: DLY_W] = dly_b_q;
			end
			`BPC_OFS_STATUS:
			begin
				rd_mux[`BPC_ST_IN]         = cell_q[`BPC_REG_IN];
				rd_mux[`BPC_ST_OUT]        = cell_q[`BPC_REG_OUT];
				rd_mux[`BPC_ST_OE]         = cell_q[`BPC_REG_OE];
				rd_mux[`BPC_ST_IN_BLOCKED] = in_blocked;
				rd_mux[`BPC_ST_MISMATCH]   = mismatch;
				rd_mux[`BPC_ST_PIN]        = pin_sync_q;
				rd_mux[`BPC_ST_CONFIGURED] = configured_q;
			end
			default:
				rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is caught one edge early and held while waitrequest is low
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_q <= 32'h0000_0000;
		else if (clk_en_i && avs_read_i && wait_q)
			rdata_q <= rd_mux;
	end

	// ==========================================
	// Configuration registers
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			mode_q    <= BPC_MODE_IN;
			oe_reg_q  <= 1'b0;
			open_dr_q <= 1'b0;
			preset_q  <= 1'b0;
		end
		else if (clk_en_i && wr_ctrl_lo)
		begin
			// Code 3 is reserved and falls back to input, the safe state
			case (avs_writedata_i[`BPC_CTRL_MODE_HI:`BPC_CTRL_MODE_LO])
				`BPC_CTRL_CODE_OUT:   mode_q <= BPC_MODE_OUT;
				`BPC_CTRL_CODE_BIDIR: mode_q <= BPC_MODE_BIDIR;
				default:              mode_q <= BPC_MODE_IN;
			endcase
			oe_reg_q  <= avs_writedata_i[`BPC_CTRL_OE_REG];
			open_dr_q <= avs_writedata_i[`BPC_CTRL_OPEN_DR];
			preset_q  <= avs_writedata_i[`BPC_CTRL_PRESET];
		end
	end

	// Apply strobe marks the end of configuration
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			apply_q      <= 1'b0;
			configured_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			apply_q <= wr_ctrl_hi & avs_writedata_i[`BPC_CTRL_APPLY];
			if (apply_q)
				configured_q <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			pwrup_q <= `BPC_PWRUP_RST;
		else if (clk_en_i && wr_pwrup)
			pwrup_q <= avs_writedata_i[`BPC_REG_OE:`BPC_REG_IN];
	end

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			dly_a_q <= `BPC_DLY_RST;
			dly_b_q <= `BPC_DLY_RST;
		end
		else if (clk_en_i && wr_delay)
		begin
			if (avs_byteenable_i[0])
				dly_a_q <= avs_writedata_i[`BPC_DLY_A_LO +: DLY_W];
			if (avs_byteenable_i[1])
				dly_b_q <= avs_writedata_i[`BPC_DLY_B_LO +: DLY_W];
		end
	end

	// ==========================================
	// Pin input: two-stage synchroniser, then the delay line
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			pin_meta_q <= pin_i;
			pin_sync_q <= pin_meta_q;
		end
	end

	// Delays are whole clock cycles; finer steps would need the analog chain
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			hist_q <= '0;
		else if (clk_en_i)
			hist_q <= {hist_q[DLY_MAX-2:0], pin_sync_q};
	end

	// Delay zero taps the synchroniser, the shortest safe latency
	assign path_a = (dly_a_q == '0) ? pin_sync_q :
		hist_q[dly_a_q - DLY_W'(1)];
	assign path_b = (dly_b_q == '0) ? pin_sync_q :
		hist_q[dly_b_q - DLY_W'(1)];

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			comb_a_q <= 1'b0;
			comb_b_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			comb_a_q <= path_a & (mode_q != BPC_MODE_OUT);
			comb_b_q <= path_b & (mode_q != BPC_MODE_OUT);
		end
	end

	// ==========================================
	// Cell registers: input, output, output enable
	// Unequal taps would offer the input register two samples
	assign in_blocked = (dly_a_q != dly_b_q);

	assign cell_d[`BPC_REG_IN]     = pin_sync_q;
	assign cell_d[`BPC_REG_OUT]    = fab_dout_i;
	assign cell_d[`BPC_REG_OE]     = fab_oe_i;

	assign cell_load[`BPC_REG_IN]  = (mode_q != BPC_MODE_OUT) &
		~in_blocked;
	assign cell_load[`BPC_REG_OUT] = (mode_q != BPC_MODE_IN);
	assign cell_load[`BPC_REG_OE]  = (mode_q == BPC_MODE_BIDIR) &
		oe_reg_q;

	// A start level that disagrees with the chosen kind ignores the clear
	assign mismatch = |(pwrup_q ^ {`BPC_CELL_REGS{preset_q}});

	// One slice per cell register, all fed by the same clear source
	genvar gi;
	generate
		for (gi = 0; gi < `BPC_CELL_REGS; gi++)
		begin : g_cell
			// Preset hits only high starters, clear only low ones
			assign acl_hit[gi] = fab_aclr_i &
				(pwrup_q[gi] == preset_q);

			always_ff @(posedge clock_i or negedge resetn_i)
			begin
				if (!resetn_i)
					cell_q[gi] <= 1'b0;
				else if (clk_en_i)
				begin
					// Apply outranks the rest so the start level lands
					if (apply_q)
						cell_q[gi] <= pwrup_q[gi];
					else if (acl_hit[gi])
						cell_q[gi] <= preset_q;
					else if (fab_sreset_i)
						cell_q[gi] <= pwrup_q[gi];
					else if (cell_load[gi])
						cell_q[gi] <= cell_d[gi];
				end
			end
		end
	endgenerate

	// ==========================================
	// Pin driver
	// Output mode drives without asking the fabric; input never drives
	always_comb
	begin
		case (mode_q)
			BPC_MODE_OUT:   eff_oe = 1'b1;
			BPC_MODE_BIDIR: eff_oe = oe_reg_q ?
				cell_q[`BPC_REG_OE] : fab_oe_i;
			default:        eff_oe = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_o_q  <= 1'b0;
			pin_oe_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			// A released open-drain pin relies on a pull-up on the board
			if (open_dr_q)
			begin
				// Only a low is ever driven so others may share the wire
				pin_o_q  <= 1'b0;
				pin_oe_q <= eff_oe & ~cell_q[`BPC_REG_OUT];
			end
			else
			begin
				pin_o_q  <= cell_q[`BPC_REG_OUT];
				pin_oe_q <= eff_oe;
			end
		end
	end

	// ==========================================
	// Outputs
	assign avs_readdata_o    = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign fab_din_o         = cell_q[`BPC_REG_IN];
	assign fab_comb_a_o      = comb_a_q;
	assign fab_comb_b_o      = comb_b_q;
	assign mode_o            = mode_q;
	assign pin_o             = pin_o_q;
	assign pin_oe_o          = pin_oe_q;
endmodule

// [dv/bpc_pin_io_cell_asserts.sv]
module bpc_pin_io_cell_asserts #(
	parameter int DLY_W = 4
) (
	input wire logic	clock_i,
	input wire logic	resetn_i,
	input wire logic	clk_en_i,
	input wire logic [3:0]	avs_address_i,
	input wire logic	avs_read_i,
	input wire logic	avs_write_i,
	input wire logic [31:0]	avs_writedata_i,
	input wire logic [3:0]	avs_byteenable_i,
	input wire logic [31:0]	avs_readdata_o,
	input wire logic	avs_waitrequest_o,
	input wire logic	fab_dout_i,
	input wire logic	fab_oe_i,
	input wire logic	fab_aclr_i,
	input wire logic	fab_sreset_i,
	input wire logic	fab_din_o,
	input wire logic	fab_comb_a_o,
	input wire logic	fab_comb_b_o,
	input wire bpc_pkg::bpc_mode_t	mode_o,
	input wire logic	pin_i,
	input wire logic	pin_o,
	input wire logic	pin_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import bpc_pkg::*;
	// ==========================================
	// Quiet time since the last bus or preset/clear activity or clock-enable-low cycle
	logic [2:0]	quiet_q;
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			quiet_q <= 3'h0;
		else if (avs_read_i || avs_write_i || fab_aclr_i || fab_sreset_i ||
			!clk_en_i)
			quiet_q <= 3'h0;
		else if (quiet_q != 3'h7)
			quiet_q <= quiet_q + 3'h1;
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	sequence s_take;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_answer;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	a_bus_answer: assert property (s_take |=> s_answer)
		else $error("bus answer late or held");
	a_wait_idle: assert property (!(avs_read_i || avs_write_i)
		&& avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest dropped without request");
	a_rdata_hold: assert property ($changed(avs_readdata_o)
		|-> !avs_waitrequest_o && $past(avs_read_i))
		else $error("read data changed outside a read");
	a_unmapped_zero: assert property (!avs_waitrequest_o && avs_read_i
		&& avs_address_i[1:0] != 2'h0 |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_out_follow: assert property (quiet_q >= 3'h4
		&& mode_o != BPC_MODE_IN && pin_oe_o |-> pin_o == $past(fab_dout_i, 2))
		else $error("driven pin differs from output register");
	a_in_float: assert property (quiet_q >= 3'h4
		&& mode_o == BPC_MODE_IN |-> !pin_oe_o)
		else $error("input pin driven");
	a_out_drive: assert property (quiet_q >= 3'h4
		&& mode_o == BPC_MODE_OUT |-> pin_oe_o || $past(fab_dout_i, 2))
		else $error("output pin released while low");
	a_din_pipe: assert property (quiet_q >= 3'h6
		&& mode_o != BPC_MODE_OUT && $changed(fab_din_o)
		|-> fab_din_o == $past(pin_i, 3))
		else $error("input register latency wrong");
endmodule

bind bpc_pin_io_cell bpc_pin_io_cell_asserts #(.DLY_W(DLY_W)) u_chk (.*);

// [dv/bpc_board_model.sv]
module bpc_board_model (
	input wire logic	pin_o,
	input wire logic	pin_oe_o,
	input wire logic	ext_en_i,
	input wire logic	ext_val_i,
	output logic	pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Shared line has a pull-up, so a released line reads high
	assign pin_i = pin_oe_o ? pin_o :
		(ext_en_i ? ext_val_i : 1'b1);
endmodule

// [dv/tb.sv]
`include "bpc_regs.svh"
`define CHK(a, b) begin check_count++; \
	if ((a) !== (b)) begin mismatches++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bpc_pkg::*;
	logic	clock_i = 1'b0;
	logic	resetn_i = 1'b0;
	logic	clk_en_i = 1'b1;
	logic [3:0]	avs_address_i = 4'h0;
	logic	avs_read_i = 1'b0;
	logic	avs_write_i = 1'b0;
	logic [31:0]	avs_writedata_i = 32'h0;
	logic [3:0]	avs_byteenable_i = 4'h3;
	logic [31:0]	avs_readdata_o;
	logic	avs_waitrequest_o;
	logic	fab_dout_i = 1'b0;
	logic	fab_oe_i = 1'b1;
	logic	fab_aclr_i = 1'b0;
	logic	fab_sreset_i = 1'b0;
	logic	fab_din_o;
	logic	fab_comb_a_o;
	logic	fab_comb_b_o;
	bpc_mode_t	mode_o;
	logic	pin_i;
	logic	pin_o;
	logic	pin_oe_o;
	logic	ext_en_i = 1'b1;
	logic	ext_val_i = 1'b0;
	logic [31:0]	seed = 32'hcc71910c;
	logic [31:0]	rd;
	logic	qp[$];
	logic	qd[$];
	logic	qe[$];
	int	mismatches = 0;
	int	check_count = 0;
	int	cyc = 0;
	bpc_pin_io_cell bpc_pin_io_cell_i (.*);
	bpc_board_model bpc_board_model_i (.*);
	always #20 clock_i = ~clock_i;
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (mismatches == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// ==========================================
	// Bus master: holds the request until waitrequest is seen low
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge clock_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		`CHK(rd, e)
	endtask
	// Model keeps driven values; index n is n cycles back
	task automatic run(input int kind, input int da, input int db);
		logic	din0;
		qp.delete();
		qd.delete();
		qe.delete();
		din0 = fab_din_o;
		repeat (24)
		begin
			@(posedge clock_i);
			seed = lfsr(seed);
			ext_val_i <= seed[0];
			fab_dout_i <= seed[1];
			fab_oe_i <= seed[2];
			qp.push_front(seed[0]);
			qd.push_front(seed[1]);
			qe.push_front(seed[2]);
			@(negedge clock_i);
			if (qp.size() > 8 && kind == 0)
			begin
				`CHK(fab_comb_a_o, qp[3 + da])
				`CHK(fab_comb_b_o, qp[3 + db])
				`CHK(fab_din_o, (da == db) ? qp[3] : din0)
			end
			if (qp.size() > 8 && kind == 1)
			begin
				`CHK(pin_o, qd[2])
				`CHK(pin_oe_o, 1'b1)
			end
			if (qp.size() > 8 && kind == 2)
			begin
				`CHK(pin_o, 1'b0)
				`CHK(pin_oe_o, !qd[2])
			end
			if (qp.size() > 8 && kind == 3)
			begin
				`CHK(pin_o, qd[2])
				`CHK(pin_oe_o, qe[2])
			end
			if (qp.size() > 8 && kind == 4)
			begin
				`CHK(pin_oe_o, qe[1])
			end
		end
	endtask
	// Clock enable low must hold every register, the pin driver too
	task automatic freeze();
		logic	v;
		seed = lfsr(seed);
		v = seed[3];
		@(posedge clock_i);
		fab_dout_i <= v;
		repeat (3) @(posedge clock_i);
		clk_en_i <= 1'b0;
		fab_dout_i <= !v;
		repeat (4) @(posedge clock_i);
		`CHK(pin_o, v)
		clk_en_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		`CHK(pin_o, !v)
	endtask
	task automatic pulse(input logic ac, input logic e);
		logic	seen;
		seen = 1'b0;
		repeat (4) @(posedge clock_i);
		fab_aclr_i <= ac;
		fab_sreset_i <= !ac;
		@(posedge clock_i);
		fab_aclr_i <= 1'b0;
		fab_sreset_i <= 1'b0;
		repeat (4)
		begin
			@(negedge clock_i);
			seen = seen | pin_o;
		end
		`CHK(seen, e)
	endtask
	initial
	begin
		repeat (3) @(posedge clock_i);
		resetn_i <= 1'b1;
		chk_rd(`BPC_OFS_CTRL, 32'h0);
		chk_rd(`BPC_OFS_PWRUP, 32'h0);
		chk_rd(`BPC_OFS_DELAY, 32'h0);
		bus(4'h2, 1'b1, 32'h1ff);
		chk_rd(4'h1, 32'h0);
		chk_rd(`BPC_OFS_CTRL, 32'h0);
		bus(`BPC_OFS_STATUS, 1'b0, 32'h0);
		`CHK(rd[6], 1'b0)
		for (int m = 0; m < 4; m++)
		begin
			bus(`BPC_OFS_CTRL, 1'b1, m);
			repeat (3) @(posedge clock_i);
			`CHK(mode_o, (m == 3) ? BPC_MODE_IN : bpc_mode_t'(m))
		end
		bus(`BPC_OFS_CTRL, 1'b1, 32'h0);
		bus(`BPC_OFS_DELAY, 1'b1, 32'h202);
		chk_rd(`BPC_OFS_DELAY, 32'h202);
		bus(`BPC_OFS_STATUS, 1'b0, 32'h0);
		`CHK(rd[3], 1'b0)
		run(0, 2, 2);
		bus(`BPC_OFS_DELAY, 1'b1, 32'h301);
		bus(`BPC_OFS_STATUS, 1'b0, 32'h0);
		`CHK(rd[3], 1'b1)
		run(0, 1, 3);
		bus(`BPC_OFS_CTRL, 1'b1, 32'h1);
		run(1, 0, 0);
		freeze();
		bus(`BPC_OFS_CTRL, 1'b1, 32'h9);
		run(2, 0, 0);
		bus(`BPC_OFS_CTRL, 1'b1, 32'h6);
		run(3, 0, 0);
		bus(`BPC_OFS_CTRL, 1'b1, 32'h2);
		run(4, 0, 0);
		fab_dout_i <= 1'b0;
		bus(`BPC_OFS_PWRUP, 1'b1, 32'h2);
		bus(`BPC_OFS_CTRL, 1'b1, 32'h111);
		bus(`BPC_OFS_STATUS, 1'b0, 32'h0);
		`CHK(rd[6], 1'b1)
		`CHK(rd[4], 1'b1)
		pulse(1'b1, 1'b1);
		pulse(1'b0, 1'b1);
		bus(`BPC_OFS_CTRL, 1'b1, 32'h101);
		pulse(1'b1, 1'b0);
		complete_run();
	end
endmodule
